/* File: logic/csr_sensor_ctrl.v */
// sensor control registers and successive-approximation sequencer
`timescale 1ns/1ps
`include "csr_sensor_defs.vh"

// Overview of operation
// - control bit seven set powers the sensor, cleared switches it off
// - three-bit mode field picks calibration, pressure, accel two, accel one, temperature, battery
// - pre-wait code 11,10,01,00 gives 10,6,4,3 clocks before comparison
// - post-wait code 11,10,01,00 gives 16,8,4,2 clocks after comparison
// - reference code is low byte plus five low bits of high register
// - with test output on, pre-wait bit zero picks 0.40 V or 1.24 V
// - during test output the data-out pin drops the serial check byte
// - writing the high reference code byte starts the measurement automatically when powered and idle
// - trial reference codes search for the comparator toggle point
// - each compare closes switch with sense low, ref high, then inverts both
module csr_sensor_ctrl #(
    parameter CODE_WIDTH = 13
)
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // special function register write port
    input wire sfr_write,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    // sense amplifier
    input wire sense_comp,
    // serial check byte from the host serial port
    input wire check_byte_out,
    // analog control
    output reg sensor_power,
    output reg [2:0] measure_select,
    output reg sense_switch_closed,
    output reg sense_drive_high,
    output reg ref_drive_high,
    output reg [CODE_WIDTH-1:0] reference_cap_code,
    // test path and data out
    output reg analog_test_out_enable,
    output reg test_ref_low_select,
    output reg data_out,
    // result
    output reg busy,
    output reg result_valid,
    output reg [CODE_WIDTH-1:0] result_code
);

localparam S_IDLE = 5'b00001;
localparam S_PRE = 5'b00010;
localparam S_SAMPLE = 5'b00100;
localparam S_POST = 5'b01000;
localparam S_STEP = 5'b10000;

reg [7:0] sensor_control;
reg [7:0] reference_code_low;
reg [7:0] reference_code_high;
reg [4:0] state;
reg [CODE_WIDTH-1:0] trial_bit;
reg [CODE_WIDTH-1:0] trial_code;
reg start_req;
reg timer_start;
reg timer_post;
wire timer_done;
wire [1:0] settle_before_wait;
wire [1:0] settle_after_wait;
wire test_on;

assign settle_before_wait = sensor_control[`CSR_PRE_MSB:`CSR_PRE_LSB];
assign settle_after_wait = sensor_control[`CSR_POST_MSB:`CSR_POST_LSB];
assign test_on = reference_code_high[`CSR_TEST_EN_BIT];

// =====================================
// register writes
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        sensor_control <= `CSR_RESET_BYTE;
        reference_code_low <= `CSR_RESET_BYTE;
        reference_code_high <= `CSR_RESET_BYTE;
        start_req <= 1'b0;
    end
    else
    begin
        start_req <= 1'b0;
        if (sfr_write)
        begin
            case (sfr_addr)
                `CSR_ADDR_SENSOR_CONTROL: sensor_control <= sfr_wdata;
                `CSR_ADDR_REF_CODE_LOW: reference_code_low <= sfr_wdata;
                `CSR_ADDR_REF_CODE_HIGH:
                begin
                    // bits 7:6 unused, kept zero
                    reference_code_high <= {2'h0, sfr_wdata[5:0]};
                    start_req <= 1'b1;
                end
                default: start_req <= 1'b0;
            endcase
        end
    end
end

// =====================================
// settle timer
csr_wait_timer u_wait
(
    .clock(clock),
    .rst_n(rst_n),
    .start(timer_start),
    .post_sel(timer_post),
    .code(timer_post ? settle_after_wait : settle_before_wait),
    .done(timer_done)
);

// =====================================
// sequencer
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        state <= S_IDLE;
        trial_bit <= {CODE_WIDTH{1'b0}};
        trial_code <= {CODE_WIDTH{1'b0}};
        timer_start <= 1'b0;
        timer_post <= 1'b0;
        sense_switch_closed <= 1'b0;
        sense_drive_high <= 1'b0;
        ref_drive_high <= 1'b0;
        reference_cap_code <= {CODE_WIDTH{1'b0}};
        busy <= 1'b0;
        result_valid <= 1'b0;
        result_code <= {CODE_WIDTH{1'b0}};
    end
    else
    begin
        timer_start <= 1'b0;
        result_valid <= 1'b0;
        if (!sensor_control[`CSR_POWER_BIT])
        begin
            state <= S_IDLE;
            busy <= 1'b0;
            sense_switch_closed <= 1'b0;
            sense_drive_high <= 1'b1;
            ref_drive_high <= 1'b0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (start_req)
                    begin
                        reference_cap_code <= {reference_code_high[`CSR_REF_HIGH_MSB:0], reference_code_low};
                        // search starts from msb set alone, not from the written code
                        trial_bit <= {1'b1, {(CODE_WIDTH-1){1'b0}}};
                        trial_code <= {1'b1, {(CODE_WIDTH-1){1'b0}}};
                        busy <= 1'b1;
                        state <= S_STEP;
                    end
                end
                S_STEP:
                begin
                    // close switch, sense low ref high
                    sense_switch_closed <= 1'b1;
                    sense_drive_high <= 1'b0;
                    ref_drive_high <= 1'b1;
                    reference_cap_code <= trial_code;
                    timer_post <= 1'b0;
                    timer_start <= 1'b1;
                    state <= S_PRE;
                end
                S_PRE:
                begin
                    if (timer_done)
                    begin
                        sense_switch_closed <= 1'b0;
                        sense_drive_high <= 1'b1;
                        ref_drive_high <= 1'b0;
                        state <= S_SAMPLE;
                    end
                end
                S_SAMPLE:
                begin
                    if (!sense_comp)
                    begin
                        trial_code <= trial_code & ~trial_bit;
                    end
                    timer_post <= 1'b1;
                    timer_start <= 1'b1;
                    state <= S_POST;
                end
                S_POST:
                begin
                    if (timer_done)
                    begin
                        if (trial_bit[0])
                        begin
                            result_code <= trial_code;
                            result_valid <= 1'b1;
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                        else
                        begin
                            trial_bit <= trial_bit >> 1;
                            trial_code <= trial_code | (trial_bit >> 1);
                            state <= S_STEP;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

// =====================================
// analog outputs and data-out mux
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        sensor_power <= 1'b0;
        measure_select <= `CSR_MODE_BATT;
        analog_test_out_enable <= 1'b0;
        test_ref_low_select <= 1'b0;
        data_out <= 1'b0;
    end
    else
    begin
        sensor_power <= sensor_control[`CSR_POWER_BIT];
        // mode passed to analog; reserved codes passed unchanged
        measure_select <= sensor_control[`CSR_MODE_MSB:`CSR_MODE_LSB];
        analog_test_out_enable <= test_on;
        test_ref_low_select <= test_on & sensor_control[`CSR_PRE_LSB];
        // check byte dropped in test mode
        data_out <= test_on ? 1'b0 : check_byte_out;
    end
end

endmodule

/* File: logic/csr_sensor_defs.vh */
// register offsets, field positions, reset values and wait counts of the sensor control
`ifndef CSR_SENSOR_DEFS_VH
`define CSR_SENSOR_DEFS_VH
`define CSR_ADDR_SENSOR_CONTROL 8'hB3
`define CSR_ADDR_REF_CODE_LOW 8'hB4
`define CSR_ADDR_REF_CODE_HIGH 8'hB5
`define CSR_RESET_BYTE 8'h00
`define CSR_POWER_BIT 7
`define CSR_MODE_MSB 6
`define CSR_MODE_LSB 4
`define CSR_POST_MSB 3
`define CSR_POST_LSB 2
`define CSR_PRE_MSB 1
`define CSR_PRE_LSB 0
`define CSR_TEST_EN_BIT 5
`define CSR_REF_HIGH_MSB 4
`define CSR_MODE_CAL 3'h7
`define CSR_MODE_PRESS_REF 3'h6
`define CSR_MODE_PRESSURE 3'h5
`define CSR_MODE_ACCEL2 3'h4
`define CSR_MODE_ACCEL1 3'h3
`define CSR_MODE_TEMP 3'h2
`define CSR_MODE_SHOCK 3'h1
`define CSR_MODE_BATT 3'h0
`define CSR_PRE_WAIT_3 5'h03
`define CSR_PRE_WAIT_4 5'h04
`define CSR_PRE_WAIT_6 5'h06
`define CSR_PRE_WAIT_10 5'h0A
`define CSR_POST_WAIT_2 5'h02
`define CSR_POST_WAIT_4 5'h04
`define CSR_POST_WAIT_8 5'h08
`define CSR_POST_WAIT_16 5'h10
`endif

/* File: logic/csr_wait_timer.v */
// wait-time decoder and down counter used for settle delays
`timescale 1ns/1ps
`include "csr_sensor_defs.vh"

module csr_wait_timer
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // control
    input wire start,
    input wire post_sel,
    input wire [1:0] code,
    // status
    output reg done
);

reg [4:0] count;
reg busy;
reg [4:0] load_value;

// =====================================
// code to cycle count
always @*
begin
    load_value = `CSR_PRE_WAIT_3;
    if (post_sel)
    begin
        case (code)
            2'h3: load_value = `CSR_POST_WAIT_16;
            2'h2: load_value = `CSR_POST_WAIT_8;
            2'h1: load_value = `CSR_POST_WAIT_4;
            default: load_value = `CSR_POST_WAIT_2;
        endcase
    end
    else
    begin
        case (code)
            2'h3: load_value = `CSR_PRE_WAIT_10;
            2'h2: load_value = `CSR_PRE_WAIT_6;
            2'h1: load_value = `CSR_PRE_WAIT_4;
            default: load_value = `CSR_PRE_WAIT_3;
        endcase
    end
end

// =====================================
// counter; done pulses after exactly load_value cycles
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        count <= 5'h00;
        busy <= 1'b0;
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start)
        begin
            count <= load_value - 5'h01;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            if (count == 5'h01 || count == 5'h00)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            count <= count - 5'h01;
        end
    end
end

endmodule

/* File: sim/csr_sensor_ctrl_asserts.sv */
// port checks of the sensor control block
`timescale 1ns/1ps
module csr_sensor_ctrl_asserts #(
    parameter CODE_WIDTH = 13
)
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register port
    input wire sfr_write,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    // outputs
    input wire sensor_power,
    input wire [2:0] measure_select,
    input wire sense_switch_closed,
    input wire sense_drive_high,
    input wire ref_drive_high,
    input wire [CODE_WIDTH-1:0] reference_cap_code,
    input wire analog_test_out_enable,
    input wire data_out,
    input wire busy,
    input wire result_valid
);
// ========================================
// mirrors and sequencer
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
a_power_mirror: assert property (
    sfr_write && sfr_addr == 8'hB3 |-> ##2 sensor_power == $past(sfr_wdata[7], 2)) else $error("power");
a_mode_mirror: assert property (
    sfr_write && sfr_addr == 8'hB3 |-> ##2 measure_select == $past(sfr_wdata[6:4], 2)) else $error("mode");
a_test_enable: assert property (
    sfr_write && sfr_addr == 8'hB5 |-> ##2 analog_test_out_enable == $past(sfr_wdata[5], 2)) else $error("test");
a_data_mute: assert property (
    analog_test_out_enable && $past(analog_test_out_enable) |-> !data_out) else $error("mute");
a_busy_end: assert property (
    result_valid |-> $fell(busy) ##1 !result_valid) else $error("end");
a_drive_closed: assert property (
    sense_switch_closed |-> !sense_drive_high && ref_drive_high) else $error("closed");
a_drive_open: assert property (
    $fell(sense_switch_closed) |-> sense_drive_high && !ref_drive_high) else $error("open");
a_code_held: assert property (
    sense_switch_closed && $past(sense_switch_closed) |-> $stable(reference_cap_code)) else $error("held");
endmodule

bind csr_sensor_ctrl csr_sensor_ctrl_asserts #(.CODE_WIDTH(CODE_WIDTH)) u_checks (
    .clock(clock), .rst_n(rst_n), .sfr_write(sfr_write), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sensor_power(sensor_power), .measure_select(measure_select), .sense_switch_closed(sense_switch_closed),
    .sense_drive_high(sense_drive_high), .ref_drive_high(ref_drive_high), .busy(busy),
    .reference_cap_code(reference_cap_code), .analog_test_out_enable(analog_test_out_enable),
    .data_out(data_out), .result_valid(result_valid));

/* File: sim/csr_sense_amp_model.sv */
// behavioural sense amplifier facing the reference array
`timescale 1ns/1ps
module csr_sense_amp_model
(
    // clock
    input wire clock,
    // analog control
    input wire sensor_power,
    input wire sense_switch_closed,
    input wire [12:0] reference_cap_code,
    // capacitance under test, in reference steps
    input wire [12:0] sense_cap,
    // comparator
    output wire sense_comp
);
reg wobble = 1'b0;
// no stable level when unpowered or held neutral
always @(posedge clock)
begin
    wobble <= ~wobble;
end
assign sense_comp = (sensor_power && !sense_switch_closed) ? (reference_cap_code <= sense_cap) : wobble;
endmodule

/* File: sim/csr_sensor_ctrl_tb_top.sv */
// self-checking bench of the sensor control block
`timescale 1ns/1ps
module csr_sensor_ctrl_tb_top;
reg clock = 1'b0;
reg rst_n = 1'b0;
reg sfr_write = 1'b0;
reg [7:0] sfr_addr = 8'h00;
reg [7:0] sfr_wdata = 8'h00;
reg check_byte_out = 1'b0;
reg [12:0] sense_cap = 13'h0000;
wire sense_comp, sensor_power, sense_switch_closed, sense_drive_high, ref_drive_high;
wire analog_test_out_enable, test_ref_low_select, data_out, busy, result_valid;
wire [2:0] measure_select;
wire [12:0] reference_cap_code, result_code;
integer bad_count = 0;
integer checks_done = 0;
integer cycles = 0;
integer base, n, i, j;
csr_sensor_ctrl dut (.clock(clock), .rst_n(rst_n), .sfr_write(sfr_write), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sense_comp(sense_comp), .check_byte_out(check_byte_out),
    .sensor_power(sensor_power), .measure_select(measure_select), .sense_switch_closed(sense_switch_closed),
    .sense_drive_high(sense_drive_high), .ref_drive_high(ref_drive_high), .busy(busy),
    .reference_cap_code(reference_cap_code), .analog_test_out_enable(analog_test_out_enable),
    .test_ref_low_select(test_ref_low_select), .data_out(data_out), .result_valid(result_valid),
    .result_code(result_code));
csr_sense_amp_model amp (.clock(clock), .sensor_power(sensor_power), .sense_switch_closed(sense_switch_closed),
    .reference_cap_code(reference_cap_code), .sense_cap(sense_cap), .sense_comp(sense_comp));
initial
begin
    forever #2.5 clock = ~clock;
end
// ========================================
// tasks
task results;
begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
end
endtask
task check(input [8*6-1:0] what, input [12:0] exp, input [12:0] got);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
    @(posedge clock) #1;
    sfr_write = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clock) #1;
    sfr_write = 1'b0;
    @(posedge clock) #1;
end
endtask
// low byte alone must not start; high byte does
task conv(input [12:0] t);
begin
    sense_cap = t;
    wr(8'hB4, t[7:0]);
    check("idle", 1'b0, busy);
    wr(8'hB5, {3'h0, t[12:8]});
    check("code", t, reference_cap_code);
    n = 0;
    while (result_valid !== 1'b1)
    begin
        @(posedge clock) #1;
        n = n + 1;
    end
    check("result", t, result_code);
end
endtask
// hang guard, well above the longest expected run
always @(posedge clock)
begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
        bad_count = bad_count + 1;
        results;
    end
end
// ========================================
// sequence
initial
begin
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check("power", 1'b0, sensor_power);
    check("code", 13'h0000, reference_cap_code);
    wr(8'hB2, 8'hFF);
    check("unmap", 1'b0, sensor_power);
    check_byte_out = 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
        // reserved codes 110 and 001 skipped on purpose
        if (i != 6 && i != 1)
        begin
            wr(8'hB3, {1'b1, i[2:0], 4'h0});
            check("mode", i[2:0], measure_select);
        end
    end
    check("power", 1'b1, sensor_power);
    check("dout", 1'b1, data_out);
    // extra cycles per 13-bit conversion over the shortest code, pre then post
    for (j = 0; j < 2; j = j + 1)
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'hB3, 8'h80 | (i[7:0] << (2 * j)));
            conv(13'h1FFF - i[12:0] * 13'h0700);
            if (i == 0)
                base = n;
            check("wait", 13 * (j + 1) * ((1 << i) - 1), n - base);
        end
    end
    conv(13'h0000);
    wr(8'hB3, 8'h81);
    wr(8'hB5, 8'h20);
    check("test", 1'b1, analog_test_out_enable);
    check("refsel", 1'b1, test_ref_low_select);
    check("dout", 1'b0, data_out);
    wr(8'hB3, 8'h80);
    check("refsel", 1'b0, test_ref_low_select);
    wr(8'hB5, 8'h00);
    check("test", 1'b0, analog_test_out_enable);
    check("dout", 1'b1, data_out);
    wr(8'hB3, 8'h00);
    check("power", 1'b0, sensor_power);
    results;
end
endmodule
